// ===== inc/dac_cal_pkg.sv
package dac_cal_pkg;
	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_UNLOCK_KEY = 8'h00;
	localparam logic [7:0] OFS_ZERO_MASK = 8'h01;
	localparam logic [7:0] OFS_SPAN_MASK = 8'h02;
	localparam logic [7:0] OFS_OUT_WORD0 = 8'h03;
	localparam logic [7:0] OFS_OUT_WORD1 = 8'h04;
	localparam logic [7:0] OFS_RANGE0 = 8'h05;
	localparam logic [7:0] OFS_RANGE1 = 8'h06;
	localparam logic [7:0] OFS_GUIDE_CMD = 8'h07;
	localparam logic [7:0] OFS_MEASURED = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h09;
	// ---------------------------------------------------------------
	// Values
	// ---------------------------------------------------------------
	localparam logic [15:0] UNLOCK_KEY = 16'h5e2a;
	localparam logic [15:0] LOCK_VALUE = 16'h0000;
	localparam logic signed [15:0] FULL_COUNT = 16'sh4e20;
	localparam logic signed [15:0] IDEAL_ZERO = 16'sh0000;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	// Measured entry in microamps: 4.000mA and 20.000mA.
	localparam logic [15:0] TARGET_LO_UA = 16'h0fa0;
	localparam logic [15:0] TARGET_HI_UA = 16'h4e20;
	localparam logic [15:0] FACTORY_LO = 16'h0000;
	localparam logic [15:0] FACTORY_HI = 16'h4e20;
	// Range codes.
	localparam logic [1:0] RANGE_4_20 = 2'h0;
	localparam logic [1:0] RANGE_0_20 = 2'h1;
	localparam logic [1:0] RANGE_0_1 = 2'h2;
	// Guided commands.
	localparam logic [15:0] CMD_SET_ZERO = 16'h0001;
	localparam logic [15:0] CMD_SET_SPAN = 16'h0002;
	localparam logic [15:0] CMD_CAL = 16'h0003;
	localparam logic [15:0] CMD_RESTORE = 16'h0004;
	localparam int NCH = 2;
endpackage : dac_cal_pkg

// ===== inc/dac_cal_if.sv
`timescale 1ns/1ns
interface dac_cal_if;
	logic signed [15:0] word;
	logic [1:0] range;
	logic [15:0] cal_lo;
	logic [15:0] cal_hi;
	logic [15:0] dac;
	modport ctl(output word, output range, output cal_lo, output cal_hi, input dac);
	modport map(input word, input range, input cal_lo, input cal_hi, output dac);
endinterface : dac_cal_if

// ===== core/dac_map.sv
`timescale 1ns/1ns
module dac_map (
	dac_cal_if.map m
);
	import dac_cal_pkg::*;
	logic signed [17:0] span;
	logic signed [17:0] frac;
	logic signed [35:0] prod;
	logic signed [17:0] raw;
	always_comb begin
		span = $signed({2'b00, m.cal_hi}) - $signed({2'b00, m.cal_lo});
		// Fraction of the 4-20 span, in counts of 20000.
		if (m.range == RANGE_0_20) begin
			// 0mA sits a quarter span below the 4mA point.
			frac = 18'(((m.word * 5) >>> 2) - 18'sd5000);
		end else if (m.range == RANGE_0_1) begin
			frac = 18'((m.word >>> 4) - 18'sd5000);
		end else begin
			frac = 18'(m.word);
		end
		prod = 36'(span * frac);
		raw = 18'($signed({2'b00, m.cal_lo}) + 18'(prod / 36'sd20000));
		if (raw < 0) begin
			m.dac = 16'h0000;
		end else if (raw > 18'sh0ffff) begin
			m.dac = 16'hffff;
		end else begin
			m.dac = raw[15:0];
		end
	end
endmodule : dac_map

// ===== core/dac_cal_ctrl.sv
`timescale 1ns/1ns
// Behaviour
// - Output word: signed, 20000 is full range
// - Key 24106 lifts trigger write protection
// - Writing zero restores write protection
// - One-hot zero mask selects channel, bit0
// - One-hot span mask selects channel, bit0
// - Trigger captures present raw DAC count
// - New endpoints apply at once
// - Sub-ranges interpolated from base endpoints
// - Set-output loads ideal 0 or 20000
// - Measured entry corrects endpoint counts
// - Restore command reinstates factory endpoints
module dac_cal_ctrl #(
	parameter int CH = dac_cal_pkg::NCH
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	output logic [15:0] rdata_r,
	output logic [15:0] dac0_r,
	output logic [15:0] dac1_r,
	output logic unlocked_r
);
	import dac_cal_pkg::*;
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic signed [15:0] word_r [CH];
	logic [1:0] range_r [CH];
	logic [15:0] lo_r [CH];
	logic [15:0] hi_r [CH];
	logic [15:0] meas_r;
	logic guide_ch_r;
	logic guide_span_r;
	logic [15:0] dac_w [CH];
	logic unlock_hit;
	typedef enum logic [1:0] {G_IDLE = 2'b01, G_SET = 2'b10} guide_t;
	guide_t g_r;

	function automatic logic [15:0] correct(input logic [15:0] cnt,
		input logic [15:0] meas, input logic [15:0] tgt);
		logic signed [17:0] d;
		d = $signed({2'b00, tgt}) - $signed({2'b00, meas});
		// One count is 0.8uA on the 16mA base span: scale by 5/4.
		correct = 16'($signed({2'b00, cnt}) + ((d * 5) >>> 2));
	endfunction : correct

	genvar gi;
	generate
		for (gi = 0; gi < CH; gi++) begin : g_map
			dac_cal_if ch_if ();
			assign ch_if.word = word_r[gi];
			assign ch_if.range = range_r[gi];
			assign ch_if.cal_lo = lo_r[gi];
			assign ch_if.cal_hi = hi_r[gi];
			assign dac_w[gi] = ch_if.dac;
			dac_map u_map (.m(ch_if));
		end
	endgenerate

	assign unlock_hit = wr_en && addr == OFS_UNLOCK_KEY;

	// ---------------------------------------------------------------
	// Write protection
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			unlocked_r <= 1'b0;
		end else if (clk_en && unlock_hit) begin
			unlocked_r <= (wdata == UNLOCK_KEY);
		end
	end

	// ---------------------------------------------------------------
	// Output words, ranges and guided sequence
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < CH; i++) begin
				word_r[i] <= RESET_WORD;
				range_r[i] <= RANGE_4_20;
			end
			meas_r <= 16'h0000;
			guide_ch_r <= 1'b0;
			guide_span_r <= 1'b0;
			g_r <= G_IDLE;
		end else if (clk_en && wr_en) begin
			if (addr == OFS_OUT_WORD0) begin
				word_r[0] <= wdata;
			end else if (addr == OFS_OUT_WORD1) begin
				word_r[1] <= wdata;
			end else if (addr == OFS_RANGE0) begin
				range_r[0] <= wdata[1:0];
			end else if (addr == OFS_RANGE1) begin
				range_r[1] <= wdata[1:0];
			end else if (addr == OFS_MEASURED) begin
				meas_r <= wdata;
			end else if (addr == OFS_GUIDE_CMD && unlocked_r) begin
				// Bit 15 carries the channel, so it is kept out of the command decode.
				case ({1'b0, wdata[14:0]})
					CMD_SET_ZERO, CMD_SET_SPAN: begin
						guide_ch_r <= wdata[15];
						guide_span_r <= (wdata[7:0] == CMD_SET_SPAN[7:0]);
						word_r[wdata[15]] <= (wdata[7:0] == CMD_SET_SPAN[7:0]) ?
							FULL_COUNT : IDEAL_ZERO;
						g_r <= G_SET;
					end
					default: begin
						g_r <= G_IDLE;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Calibration endpoints
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < CH; i++) begin
				lo_r[i] <= FACTORY_LO;
				hi_r[i] <= FACTORY_HI;
			end
		end else if (clk_en && wr_en && unlocked_r) begin
			for (int i = 0; i < CH; i++) begin
				if (addr == OFS_ZERO_MASK && wdata == 16'(1 << i)) begin
					lo_r[i] <= dac_w[i];
				end else if (addr == OFS_SPAN_MASK && wdata == 16'(1 << i)) begin
					hi_r[i] <= dac_w[i];
				end else if (addr == OFS_GUIDE_CMD && wdata == CMD_RESTORE) begin
					lo_r[i] <= FACTORY_LO;
					hi_r[i] <= FACTORY_HI;
				end else if (addr == OFS_GUIDE_CMD && wdata == CMD_CAL &&
					g_r == G_SET && guide_ch_r == i[0]) begin
					if (guide_span_r) begin
						hi_r[i] <= correct(dac_w[i], meas_r, TARGET_HI_UA);
					end else begin
						lo_r[i] <= correct(dac_w[i], meas_r, TARGET_LO_UA);
					end
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Read port and DAC outputs
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_r <= 16'h0000;
		end else if (clk_en && rd_en) begin
			if (addr == OFS_UNLOCK_KEY) begin
				rdata_r <= unlocked_r ? UNLOCK_KEY : LOCK_VALUE;
			end else if (addr == OFS_OUT_WORD0) begin
				rdata_r <= word_r[0];
			end else if (addr == OFS_OUT_WORD1) begin
				rdata_r <= word_r[1];
			end else if (addr == OFS_RANGE0) begin
				rdata_r <= {14'h0000, range_r[0]};
			end else if (addr == OFS_RANGE1) begin
				rdata_r <= {14'h0000, range_r[1]};
			end else if (addr == OFS_MEASURED) begin
				rdata_r <= meas_r;
			end else if (addr == OFS_STATUS) begin
				rdata_r <= {13'h0000, guide_span_r, guide_ch_r, unlocked_r};
			end else begin
				// Trigger masks are write-only and read as zero.
				rdata_r <= 16'h0000;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dac0_r <= 16'h0000;
			dac1_r <= 16'h0000;
		end else if (clk_en) begin
			dac0_r <= dac_w[0];
			dac1_r <= dac_w[1];
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_key_unlocks: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && unlock_hit && wdata == UNLOCK_KEY |=> unlocked_r)
		else $error("key did not unlock");
	a_zero_locks: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && unlock_hit && wdata == LOCK_VALUE |=> !unlocked_r)
		else $error("zero did not lock");
	a_zero_capture: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && wr_en && unlocked_r && addr == OFS_ZERO_MASK && wdata == 16'h0001
		|=> lo_r[0] == $past(dac_w[0]))
		else $error("zero capture missed");
	a_span_capture: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && wr_en && unlocked_r && addr == OFS_SPAN_MASK && wdata == 16'h0002
		|=> hi_r[1] == $past(dac_w[1]))
		else $error("span capture missed");
	a_locked_keep: assert property (@(posedge ref_clk) disable iff (rst)
		!unlocked_r |=> $stable(lo_r[0]) && $stable(hi_r[0]))
		else $error("locked endpoint changed");
	a_restore_fact: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && wr_en && unlocked_r && addr == OFS_GUIDE_CMD && wdata == CMD_RESTORE
		|=> lo_r[1] == FACTORY_LO && hi_r[1] == FACTORY_HI)
		else $error("restore failed");
	a_ideal_span: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && wr_en && unlocked_r && addr == OFS_GUIDE_CMD &&
		wdata[14:0] == CMD_SET_SPAN[14:0]
		|=> (word_r[0] == FULL_COUNT || $past(wdata[15])) &&
		(word_r[1] == FULL_COUNT || !$past(wdata[15])))
		else $error("ideal span not loaded");
	a_dac_follow: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en |=> dac0_r == $past(dac_w[0]))
		else $error("dac output lagging");
	c_unlock: cover property (@(posedge ref_clk) unlocked_r);
	c_zero: cover property (@(posedge ref_clk) wr_en && unlocked_r && addr == OFS_ZERO_MASK);
	c_guided: cover property (@(posedge ref_clk) g_r == G_SET && wr_en && wdata == CMD_CAL);
endmodule : dac_cal_ctrl

// ===== test/cal_host_model.sv
`timescale 1ns/1ns
module cal_host_model (
	input wire logic ref_clk,
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] addr,
	output logic [15:0] wdata,
	input wire logic [15:0] rdata_r
);
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'hff;
		wdata = 16'hffff;
	end
	// ---------------------------------------------------------------
	// Host accesses
	// ---------------------------------------------------------------
	// Released address and data are inverted so that stale values are never read as valid.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		#1;
		wr_en = 1'b1;
		addr = a;
		wdata = d;
		@(posedge ref_clk);
		#1;
		wr_en = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		#1;
		rd_en = 1'b1;
		addr = a;
		@(posedge ref_clk);
		#1;
		rd_en = 1'b0;
		addr = ~a;
		@(posedge ref_clk);
		#1;
		d = rdata_r;
	endtask : rd
endmodule : cal_host_model

// ===== test/output_dac_calibration_control_tb.sv
`timescale 1ns/1ns
module output_dac_calibration_control_tb;
	import dac_cal_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic wr_en, rd_en;
	logic [7:0] addr;
	logic [15:0] wdata, rdata_r, dac0_r, dac1_r, rd_val;
	logic unlocked_r;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	always #5 ref_clk = ~ref_clk;
	cal_host_model h (.ref_clk(ref_clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wdata(wdata), .rdata_r(rdata_r));
	dac_cal_ctrl #(.CH(NCH)) uut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .wr_en(wr_en),
		.rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata_r(rdata_r), .dac0_r(dac0_r),
		.dac1_r(dac1_r), .unlocked_r(unlocked_r));
	// ---------------------------------------------------------------
	// Checking and closing
	// ---------------------------------------------------------------
	task automatic chk(input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk
	task automatic settle();
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : settle
	task automatic print_verdict();
		$display("comparisons=%0d mismatches=%0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict
	// The whole sequence needs about 140 cycles.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			print_verdict();
		end
	end
	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		repeat (12) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		chk(16'h0000, {15'h0, unlocked_r});
		chk(16'h0000, dac0_r);
		h.wr(OFS_OUT_WORD0, 16'h03e8);
		settle();
		chk(16'h03e8, dac0_r);
		h.wr(OFS_ZERO_MASK, 16'h0001);
		h.wr(OFS_OUT_WORD0, 16'h0000);
		settle();
		chk(16'h0000, dac0_r);
		$display("test locked done");
		h.wr(OFS_UNLOCK_KEY, UNLOCK_KEY);
		settle();
		chk(16'h0001, {15'h0, unlocked_r});
		h.rd(OFS_STATUS, rd_val);
		chk(16'h0001, rd_val & 16'h0001);
		h.rd(8'h0a, rd_val);
		chk(16'h0000, rd_val);
		h.wr(OFS_RANGE0, {14'h0, RANGE_4_20});
		h.wr(OFS_OUT_WORD0, 16'h03e8);
		settle();
		h.wr(OFS_ZERO_MASK, 16'h0001);
		h.wr(OFS_OUT_WORD0, 16'h0000);
		settle();
		chk(16'h03e8, dac0_r);
		h.wr(OFS_OUT_WORD0, 16'h2710);
		settle();
		chk(16'h2904, dac0_r);
		h.wr(OFS_OUT_WORD1, 16'h4a38);
		settle();
		h.wr(OFS_SPAN_MASK, 16'h0002);
		h.wr(OFS_OUT_WORD1, 16'h4e20);
		settle();
		chk(16'h4a38, dac1_r);
		h.wr(OFS_SPAN_MASK, 16'h0003);
		h.wr(OFS_OUT_WORD0, 16'h4e20);
		settle();
		chk(16'h4e20, dac0_r);
		$display("test capture done");
		h.wr(OFS_UNLOCK_KEY, LOCK_VALUE);
		settle();
		chk(16'h0000, {15'h0, unlocked_r});
		h.wr(OFS_ZERO_MASK, 16'h0001);
		h.wr(OFS_OUT_WORD0, 16'h0000);
		settle();
		chk(16'h03e8, dac0_r);
		h.wr(OFS_GUIDE_CMD, CMD_RESTORE);
		settle();
		chk(16'h03e8, dac0_r);
		$display("test relock done");
		h.wr(OFS_UNLOCK_KEY, UNLOCK_KEY);
		h.wr(OFS_GUIDE_CMD, CMD_RESTORE);
		settle();
		chk(16'h0000, dac0_r);
		h.wr(OFS_GUIDE_CMD, CMD_SET_SPAN | 16'h8000);
		settle();
		chk(16'h4e20, dac1_r);
		h.wr(OFS_GUIDE_CMD, CMD_SET_ZERO);
		settle();
		chk(16'h0000, dac0_r);
		h.wr(OFS_MEASURED, 16'h0f3c);
		h.wr(OFS_GUIDE_CMD, CMD_CAL);
		settle();
		chk(16'h007d, dac0_r);
		$display("test guided done");
		h.wr(OFS_OUT_WORD1, 16'h1388);
		settle();
		h.wr(OFS_ZERO_MASK, 16'h0002);
		h.wr(OFS_RANGE1, {14'h0, RANGE_0_20});
		h.wr(OFS_OUT_WORD1, 16'h2710);
		settle();
		chk(16'h2981, dac1_r);
		h.wr(OFS_RANGE1, {14'h0, RANGE_0_1});
		h.wr(OFS_OUT_WORD1, 16'h4e20);
		settle();
		chk(16'h088c, dac1_r);
		// With the enable low the write must be lost and the output must hold.
		clk_en = 1'b0;
		h.wr(OFS_OUT_WORD1, 16'h0000);
		settle();
		chk(16'h088c, dac1_r);
		clk_en = 1'b1;
		$display("test subrange done");
		print_verdict();
	end
endmodule : output_dac_calibration_control_tb
